/* File: include/rst_ctrl_pkg.sv */
// Constants for the reset source controller.
// Assumes a 100 MHz core clock; analog comparators arrive as async levels.
package rst_ctrl_pkg;
   localparam int          CLOCK_HZ            = 100_000_000;
   // Extra hold after the reset pin releases, in microseconds
   localparam int          RELEASE_DELAY_US    = 10;
   localparam int          RELEASE_DELAY_CYC   = RELEASE_DELAY_US * (CLOCK_HZ / 1_000_000);
   // Least time a supply dip must last to count, in microseconds (rounded up)
   localparam int          QUALIFY_US          = 1;
   localparam int          QUALIFY_CYC         = QUALIFY_US * (CLOCK_HZ / 1_000_000);
   localparam int          CNT_W               = 16;
   localparam int          PC_W                = 11;
   localparam int          SP_W                = 3;
   localparam int          PORT_W              = 8;
   localparam int          PORT_N              = 5;
   localparam logic [PC_W-1:0]   PC_RESET      = 11'h000;
   localparam logic [SP_W-1:0]   SP_TOP        = 3'h0;
   localparam logic [PORT_W-1:0] PORT_RESET    = 8'hff;
   // Status bit positions in the event register
   localparam int          EV_PIN              = 0;
   localparam int          EV_LOWSUP           = 1;
   localparam int          EV_WD_RUN           = 2;
   localparam int          EV_WD_HALT          = 3;
   localparam int          EV_W                = 4;
   // APB byte offsets
   localparam logic [7:0]  OFS_FLAGS           = 8'h00;
   localparam logic [7:0]  OFS_CFG             = 8'h04;
   localparam logic [7:0]  OFS_EVENT           = 8'h08;
   localparam logic [7:0]  OFS_MASK            = 8'h0c;
   localparam logic [7:0]  OFS_STATE           = 8'h10;
   localparam logic [31:0] CFG_RESET           = 32'h0000_0001;
   // Configuration field positions
   localparam int          CFG_DET_EN          = 0;
   localparam int          CFG_THR_LSB         = 1;
   localparam int          CFG_TMR_ON          = 4;
   localparam int          CFG_INT_ON          = 5;

   typedef enum logic [1:0] {ST_HOLD, ST_DELAY, ST_RUN, ST_HALT} seq_state_t;
endpackage

/* File: rtl/rst_ctrl.sv */
// Reset source controller: merges power-on, pin, low supply and run-state watchdog
// resets into one core reset, tracks the two status flags, APB registers.
// Assumes analog detector outputs and the pin are asynchronous to clock_i.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module rst_ctrl
   import rst_ctrl_pkg::*;
(
   // Clock and power-on reset
   input  wire logic               clock_i,
   input  wire logic               resetn_i,
   // Reset sources and halt request
   input  wire logic               external_reset_pin_n_i,
   input  wire logic               low_supply_i,
   input  wire logic               watchdog_timeout_i,
   input  wire logic               halt_i,
   // Core reset controls
   output logic                    core_reset_n_o,
   output logic                    pc_clear_o,
   output logic                    sp_clear_o,
   output logic                    state_reset_o,
   output logic                    watchdog_clear_o,
   output logic [1:0]              low_supply_threshold_o,
   output logic                    watchdog_timeout_flag_o,
   output logic                    powerdown_flag_o,
   output logic [PC_W-1:0]         pc_reset_o,
   output logic [SP_W-1:0]         sp_reset_o,
   output logic [PORT_W*PORT_N-1:0] port_reset_o,
   output logic                    timer_enable_o,
   output logic                    int_enable_o,
   // APB slave
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [7:0]         paddr_i,
   input  wire logic [31:0]        pwdata_i,
   output logic [31:0]             prdata_o,
   output logic                    pready_o,
   output logic                    pslverr_o,
   output logic                    irq_o
);

   typedef struct packed {
      logic [2:0]       pin_sync;
      logic [2:0]       low_sync;
      logic             pin_level;
      logic             low_level;
      seq_state_t       state;
      logic [CNT_W-1:0] startup_delay_counter;
      logic [CNT_W-1:0] qualify_cnt;
      logic             to_flag;
      logic             pd_flag;
      logic [31:0]      cfg;
      logic [EV_W-1:0]  events;
      logic [EV_W-1:0]  mask;
      logic             core_rst_n;
      logic             pc_clr;
      logic             sp_clr;
      logic             st_rst;
      logic             wd_clr;
      logic             tmr_en;
      logic             int_en;
      logic [31:0]      rdata;
      logic             ready;
      logic             slverr;
      logic             irq;
   } state_t;

   state_t s_reg;
   state_t s_next;

   function automatic logic [31:0] rd_mux(input state_t s, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         OFS_FLAGS: r = {30'h0, s.pd_flag, s.to_flag};
         OFS_CFG:   r = s.cfg;
         OFS_EVENT: r = {28'h0, s.events};
         OFS_MASK:  r = {28'h0, s.mask};
         OFS_STATE: r = {29'h0, s.core_rst_n, s.state};
         default:   r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   logic            access;
   logic            wr_hit;
   logic            pin_rst;
   logic            low_rst;
   logic [EV_W-1:0] ev_set;

   always_comb begin
      s_next = s_reg;
      access = psel_i && penable_i && !s_reg.ready;
      wr_hit = access && pwrite_i;
      // Three-stage synchroniser; a change counts when stages two and three agree
      s_next.pin_sync = {s_reg.pin_sync[1:0], external_reset_pin_n_i};
      s_next.low_sync = {s_reg.low_sync[1:0], low_supply_i};
      if (s_reg.pin_sync[2] == s_reg.pin_sync[1]) begin
         s_next.pin_level = s_reg.pin_sync[2];
      end
      if (s_reg.low_sync[2] == s_reg.low_sync[1]) begin
         s_next.low_level = s_reg.low_sync[2];
      end
      // Detector disabled by option: dips are never counted
      if (s_reg.low_level && s_reg.cfg[CFG_DET_EN]) begin
         if (s_reg.qualify_cnt <= CNT_W'(QUALIFY_CYC)) begin
            s_next.qualify_cnt = s_reg.qualify_cnt + 1'b1;
         end
      end else begin
         s_next.qualify_cnt = '0;
      end
      pin_rst = !s_reg.pin_level;
      low_rst = s_reg.qualify_cnt > CNT_W'(QUALIFY_CYC);
      ev_set  = '0;
      s_next.pc_clr = 1'b0;
      s_next.sp_clr = 1'b0;
      s_next.wd_clr = 1'b0;
      unique case (s_reg.state)
         ST_HOLD: begin
            s_next.core_rst_n = 1'b0;
            s_next.st_rst     = 1'b1;
            s_next.tmr_en     = 1'b0;
            s_next.int_en     = 1'b0;
            if (!pin_rst && !low_rst) begin
               s_next.state = ST_DELAY;
               s_next.startup_delay_counter = '0;
            end
         end
         ST_DELAY: begin
            s_next.startup_delay_counter = s_reg.startup_delay_counter + 1'b1;
            if (pin_rst || low_rst) begin
               s_next.state = ST_HOLD;
            end else if (s_reg.startup_delay_counter >= CNT_W'(RELEASE_DELAY_CYC - 1)) begin
               s_next.state      = ST_RUN;
               s_next.core_rst_n = 1'b1;
               s_next.st_rst     = 1'b0;
               s_next.wd_clr     = 1'b1;
               s_next.tmr_en     = s_reg.cfg[CFG_TMR_ON];
               s_next.int_en     = s_reg.cfg[CFG_INT_ON];
            end
         end
         ST_RUN: begin
            if (pin_rst || low_rst) begin
               // Flags are left alone
               s_next.state      = ST_HOLD;
               s_next.core_rst_n = 1'b0;
               ev_set[EV_PIN]    = pin_rst;
               ev_set[EV_LOWSUP] = low_rst;
            end else if (watchdog_timeout_i) begin
               s_next.state      = ST_HOLD;
               s_next.core_rst_n = 1'b0;
               s_next.to_flag    = 1'b1;
               ev_set[EV_WD_RUN] = 1'b1;
            end else if (halt_i) begin
               s_next.state   = ST_HALT;
               s_next.pd_flag = 1'b1;
               s_next.to_flag = 1'b0;
               s_next.wd_clr  = 1'b1;
            end
         end
         ST_HALT: begin
            if (pin_rst || low_rst) begin
               s_next.state      = ST_HOLD;
               s_next.core_rst_n = 1'b0;
               ev_set[EV_PIN]    = pin_rst;
               ev_set[EV_LOWSUP] = low_rst;
            end else if (watchdog_timeout_i) begin
               // Warm reset: only PC and SP cleared, core keeps running state
               s_next.state       = ST_RUN;
               s_next.pc_clr      = 1'b1;
               s_next.sp_clr      = 1'b1;
               s_next.to_flag     = 1'b1;
               s_next.pd_flag     = 1'b1;
               ev_set[EV_WD_HALT] = 1'b1;
            end
         end
      endcase
      // Any path into reset drops the enables in that same cycle, not one later
      if (!s_next.core_rst_n) begin
         s_next.st_rst = 1'b1;
         s_next.tmr_en = 1'b0;
         s_next.int_en = 1'b0;
      end
      // APB slave with one wait state; unmapped reads give zero and an error
      s_next.ready  = access;
      s_next.slverr = access && !(paddr_i inside {OFS_FLAGS, OFS_CFG, OFS_EVENT,
                                                  OFS_MASK, OFS_STATE});
      if (access && !pwrite_i) begin
         s_next.rdata = rd_mux(s_reg, paddr_i);
      end
      if (wr_hit && paddr_i == OFS_CFG) begin
         s_next.cfg = pwdata_i;
      end
      if (wr_hit && paddr_i == OFS_MASK) begin
         s_next.mask = pwdata_i[EV_W-1:0];
      end
      // Set wins over write-one-to-clear
      if (wr_hit && paddr_i == OFS_EVENT) begin
         s_next.events = (s_reg.events & ~pwdata_i[EV_W-1:0]) | ev_set;
      end else begin
         s_next.events = s_reg.events | ev_set;
      end
      s_next.irq = |(s_next.events & s_next.mask);
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         s_reg            <= '0;
         s_reg.pin_sync   <= 3'h0;
         s_reg.state      <= ST_HOLD;
         s_reg.to_flag    <= 1'b0;
         s_reg.pd_flag    <= 1'b0;
         s_reg.cfg        <= CFG_RESET;
         s_reg.st_rst     <= 1'b1;
         s_reg.core_rst_n <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign core_reset_n_o          = s_reg.core_rst_n;
   assign pc_clear_o              = s_reg.pc_clr;
   assign sp_clear_o              = s_reg.sp_clr;
   assign state_reset_o           = s_reg.st_rst;
   assign watchdog_clear_o        = s_reg.wd_clr;
   assign low_supply_threshold_o  = s_reg.cfg[CFG_THR_LSB +: 2];
   assign watchdog_timeout_flag_o = s_reg.to_flag;
   assign powerdown_flag_o        = s_reg.pd_flag;
   assign pc_reset_o              = PC_RESET;
   assign sp_reset_o              = SP_TOP;
   assign port_reset_o            = {PORT_N{PORT_RESET}};
   assign timer_enable_o          = s_reg.tmr_en;
   assign int_enable_o            = s_reg.int_en;
   assign prdata_o                = s_reg.rdata;
   assign pready_o                = s_reg.ready;
   assign pslverr_o               = s_reg.slverr;
   assign irq_o                   = s_reg.irq;

   // Assertions
   // Reference count of a qualifying dip, kept apart from the design counter
   int dip_cnt;
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         dip_cnt <= 0;
      end else if (s_reg.low_level && s_reg.cfg[CFG_DET_EN]) begin
         dip_cnt <= dip_cnt + 1;
      end else begin
         dip_cnt <= 0;
      end
   end

   // Sequencing and reset outputs
   hold_on_pin_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      !s_reg.pin_level |=> !core_reset_n_o)
      else $error("core left reset while pin low");
   release_delay_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      $rose(core_reset_n_o) |-> $past(s_reg.state) == ST_DELAY
          && $past(s_reg.startup_delay_counter) == CNT_W'(RELEASE_DELAY_CYC - 1))
      else $error("release without delay");
   core_state_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      core_reset_n_o == (s_reg.state inside {ST_RUN, ST_HALT}))
      else $error("core reset does not follow sequencer");
   reset_pair_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      core_reset_n_o != state_reset_o)
      else $error("core reset and state reset disagree");
   ints_off_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      !core_reset_n_o |-> !int_enable_o && !timer_enable_o)
      else $error("interrupt or timer on in reset");
   por_state_a: assert property (@(posedge clock_i)
      !resetn_i |=> !core_reset_n_o && state_reset_o && !int_enable_o && !timer_enable_o)
      else $error("power-on outputs wrong");
   por_flags_a: assert property (@(posedge clock_i)
      !resetn_i |=> !watchdog_timeout_flag_o && !powerdown_flag_o)
      else $error("power-on flags not cleared");
   wd_clear_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      $rose(core_reset_n_o) |-> watchdog_clear_o)
      else $error("watchdog not cleared");

   // Flags and warm reset clears
   pin_flags_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s_reg.state == ST_RUN && !s_reg.pin_level)
      |=> $stable(watchdog_timeout_flag_o) && $stable(powerdown_flag_o))
      else $error("pin reset changed flags");
   low_flags_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s_reg.state == ST_RUN && low_rst)
      |=> $stable(watchdog_timeout_flag_o) && $stable(powerdown_flag_o))
      else $error("low supply reset changed flags");
   halt_keep_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s_reg.state == ST_HALT && !watchdog_timeout_i)
      |=> $stable(watchdog_timeout_flag_o) && $stable(powerdown_flag_o))
      else $error("flags moved in power-down");
   wd_run_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s_reg.state == ST_RUN && s_reg.pin_level && !low_rst && watchdog_timeout_i)
      |=> watchdog_timeout_flag_o && !core_reset_n_o)
      else $error("watchdog run reset wrong");
   wd_halt_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s_reg.state == ST_HALT && s_reg.pin_level && !low_rst && watchdog_timeout_i)
      |=> pc_clear_o && sp_clear_o && watchdog_timeout_flag_o && powerdown_flag_o
          && core_reset_n_o)
      else $error("warm reset wrong");
   halt_flags_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s_reg.state == ST_RUN && s_reg.pin_level && !low_rst && !watchdog_timeout_i && halt_i)
      |=> powerdown_flag_o && !watchdog_timeout_flag_o)
      else $error("halt flags wrong");
   halt_wdclr_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s_reg.state == ST_RUN && s_reg.pin_level && !low_rst && !watchdog_timeout_i && halt_i)
      |=> watchdog_clear_o)
      else $error("watchdog not cleared on halt");
   warm_pulse_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      pc_clear_o |=> !pc_clear_o)
      else $error("warm reset pulse too long");
   clear_pair_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      pc_clear_o == sp_clear_o)
      else $error("counter and stack clears split");

   // Low supply detector
   short_dip_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      low_rst |-> $past(s_reg.cfg[CFG_DET_EN]) && $past(s_reg.low_level, 1))
      else $error("dip not qualified");
   dip_length_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      low_rst == (dip_cnt > QUALIFY_CYC))
      else $error("dip qualify length wrong");
   detector_off_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      !s_reg.cfg[CFG_DET_EN] |=> !low_rst)
      else $error("disabled detector still resets");
   low_reset_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s_reg.state == ST_RUN && low_rst) |=> !core_reset_n_o)
      else $error("low supply did not reset");

   // Register bus and interrupt
   apb_answer_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (psel_i && penable_i && !pready_o) |=> pready_o)
      else $error("no answer after wait state");
   ready_pulse_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      pready_o |=> !pready_o)
      else $error("ready held too long");
   slverr_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      pslverr_o |-> pready_o)
      else $error("error without ready");
   sticky_events_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      !(wr_hit && paddr_i == OFS_EVENT)
      |=> (s_reg.events & $past(s_reg.events)) == $past(s_reg.events))
      else $error("event bit lost without clear");
   irq_level_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      irq_o == |(s_reg.events & s_reg.mask))
      else $error("interrupt level wrong");

   pin_reset_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
      s_reg.state == ST_RUN ##1 s_reg.state == ST_HOLD);
   warm_reset_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
      $rose(pc_clear_o));
   halt_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
      s_reg.state == ST_HALT);
   low_c: cover property (@(posedge clock_i) disable iff (!resetn_i) low_rst);
   enables_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
      $rose(int_enable_o));
endmodule

/* File: tb/rc_reset_net.sv */
// Model of the RC network and push switch on the external reset pin.
// Assumes one clock; the pull-up makes a released pin read high.
`timescale 1ns/1ps
module rc_reset_net #(
   parameter int HOLD_CYC = 40
) (
   // Clock and switch
   input  wire logic clock_i,
   input  wire logic press_i,
   // Pin
   output logic      pin_n_o
);
   int charge_cnt = 0;
   // Capacitor charge keeps the pin low long after power-up
   always_ff @(posedge clock_i) begin
      if (charge_cnt < HOLD_CYC) begin
         charge_cnt <= charge_cnt + 1;
      end
   end
   assign pin_n_o = (charge_cnt >= HOLD_CYC) && !press_i;
endmodule

/* File: tb/rst_ctrl_tb.sv */
// Testbench for the reset source controller: APB tasks, pin switch model,
// watchdog, halt and supply stimulus. Assumes one APB wait state or more.
`timescale 1ns/1ps
module rst_ctrl_tb;
   import rst_ctrl_pkg::*;
   logic                     clock_i, resetn_i, press, pin_n, low_sup, wd_to, halt;
   logic                     psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0]               paddr;
   logic [31:0]              pwdata, prdata, rd;
   logic                     core_rst_n, pc_clr, sp_clr, st_rst, wd_clr;
   logic                     to_flag, pd_flag, tmr_en, int_en;
   logic [1:0]               thr;
   logic [PC_W-1:0]          pc_rst;
   logic [SP_W-1:0]          sp_rst;
   logic [PORT_W*PORT_N-1:0] port_rst;
   int                       miscompares = 0, samples_checked = 0;
   int                       pc_pulses = 0, wdc_pulses = 0, n, mark;

   rc_reset_net #(.HOLD_CYC(40)) u_rc_reset_net (.clock_i(clock_i), .press_i(press),
      .pin_n_o(pin_n));
   rst_ctrl u_rst_ctrl (.clock_i(clock_i), .resetn_i(resetn_i),
      .external_reset_pin_n_i(pin_n), .low_supply_i(low_sup), .watchdog_timeout_i(wd_to),
      .halt_i(halt), .core_reset_n_o(core_rst_n), .pc_clear_o(pc_clr), .sp_clear_o(sp_clr),
      .state_reset_o(st_rst), .watchdog_clear_o(wd_clr), .low_supply_threshold_o(thr),
      .watchdog_timeout_flag_o(to_flag), .powerdown_flag_o(pd_flag), .pc_reset_o(pc_rst),
      .sp_reset_o(sp_rst), .port_reset_o(port_rst), .timer_enable_o(tmr_en),
      .int_enable_o(int_en), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .irq_o(irq));

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   always @(posedge clock_i) begin
      pc_pulses <= pc_pulses + int'(pc_clr && sp_clr);
      wdc_pulses <= wdc_pulses + int'(wd_clr);
   end

   task automatic test_done();
      $display("samples_checked=%0d miscompares=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Holds the request until pready is sampled high; result in rd and err
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      do begin
         @(posedge clock_i);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         chk(pready, 1'b1);
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_core(input logic v, input int lim);
      n = 0;
      while (core_rst_n !== v && n < lim) begin
         @(posedge clock_i);
         n++;
      end
      if (n >= lim) begin
         chk(core_rst_n, v);
         test_done();
      end
   endtask

   task automatic flags(input logic [1:0] exp);
      chk({pd_flag, to_flag}, exp);
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(rd, {30'h0, exp});
   endtask

   task automatic pulse(input bit wd);
      @(posedge clock_i);
      wd_to <= wd;
      halt <= !wd;
      @(posedge clock_i);
      wd_to <= 1'b0;
      halt <= 1'b0;
      repeat (3) @(posedge clock_i);
   endtask

   // Enables seen after release are given by en as {int, timer}
   task automatic pin_reset(input logic [1:0] en);
      @(posedge clock_i);
      press <= 1'b1;
      repeat (20) @(posedge clock_i);
      chk({core_rst_n, int_en, tmr_en}, 3'h0);
      press <= 1'b0;
      wait_core(1'b1, RELEASE_DELAY_CYC + 50);
      chk({int_en, tmr_en}, en);
   endtask

   task automatic dip(input int len);
      @(posedge clock_i);
      low_sup <= 1'b1;
      repeat (len) @(posedge clock_i);
      low_sup <= 1'b0;
      repeat (5) @(posedge clock_i);
   endtask

   task automatic irq_chk(input logic [7:0] a, input logic [31:0] d, input logic exp);
      apb(1'b1, a, d);
      repeat (2) @(posedge clock_i);
      chk(irq, exp);
   endtask

   initial begin
      resetn_i = 1'b0;
      press = 1'b0;
      low_sup = 1'b0;
      wd_to = 1'b0;
      halt = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (12) @(posedge clock_i);
      chk({core_rst_n, st_rst, int_en, tmr_en}, 4'h4);
      chk({pc_rst, sp_rst}, {PC_RESET, SP_TOP});
      chk(port_rst, {PORT_N{PORT_RESET}});
      chk({pd_flag, to_flag}, 2'h0);
      resetn_i <= 1'b1;
      repeat (20) @(posedge clock_i);
      chk(core_rst_n, 1'b0);
      wait_core(1'b1, RELEASE_DELAY_CYC + 60);
      chk(n > RELEASE_DELAY_CYC && n < RELEASE_DELAY_CYC + 24, 1'b1);
      chk(st_rst, 1'b0);
      flags(2'h0);
      apb(1'b0, OFS_CFG, 32'h0);
      chk(rd, CFG_RESET);
      // Watchdog while running
      mark = wdc_pulses;
      pulse(1'b1);
      chk(core_rst_n, 1'b0);
      flags(2'h1);
      wait_core(1'b1, RELEASE_DELAY_CYC + 50);
      repeat (2) @(posedge clock_i);
      chk(wdc_pulses > mark, 1'b1);
      pin_reset(2'h0);
      flags(2'h1);
      // Halt, then watchdog in power-down is a warm reset
      pulse(1'b0);
      flags(2'h2);
      mark = pc_pulses;
      pulse(1'b1);
      chk({pc_pulses - mark, core_rst_n}, {32'h1, 1'b1});
      flags(2'h3);
      pin_reset(2'h0);
      flags(2'h3);
      // Short dip ignored, long dip resets
      apb(1'b1, OFS_EVENT, 32'hf);
      dip(50);
      chk(core_rst_n, 1'b1);
      dip(150);
      chk(core_rst_n, 1'b0);
      wait_core(1'b1, RELEASE_DELAY_CYC + 50);
      flags(2'h3);
      apb(1'b0, OFS_EVENT, 32'h0);
      chk(rd, 32'h1 << EV_LOWSUP);
      irq_chk(OFS_MASK, 32'h1 << EV_LOWSUP, 1'b1);
      irq_chk(OFS_MASK, 32'h0, 1'b0);
      irq_chk(OFS_MASK, 32'h1 << EV_LOWSUP, 1'b1);
      irq_chk(OFS_EVENT, 32'h1 << EV_LOWSUP, 1'b0);
      // Enables taken at release; the next reset must drop them at once
      apb(1'b1, OFS_CFG, 32'h31);
      pin_reset(2'h3);
      pin_reset(2'h3);
      flags(2'h3);
      apb(1'b1, 8'h20, 32'hf);
      chk(err, 1'b1);
      // Detector off with a new threshold
      apb(1'b1, OFS_CFG, 32'h4);
      repeat (2) @(posedge clock_i);
      chk(thr, 2'h2);
      dip(150);
      chk(core_rst_n, 1'b1);
      apb(1'b0, 8'h20, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      test_done();
   end
endmodule
